// ---- ost_pkg.sv ----
// constants for the one-time overflow supervisor timer
package ost_pkg;
   localparam logic [7:0]  RESTART_KEY_ADDR  = 8'ha6;
   localparam logic [7:0]  KEY_FIRST         = 8'h1e;
   localparam logic [7:0]  KEY_SECOND        = 8'he1;
   localparam int          COUNT_W           = 14;
   localparam logic [13:0] COUNT_RESET       = 14'h0000;
   localparam logic [13:0] COUNT_TERMINAL    = 14'h3fff;
   localparam int          TICK_DIV_SIX      = 6;
   localparam int          TICK_DIV_TWELVE   = 12;
   localparam logic [3:0]  TICK_LAST_SIX     = 4'(TICK_DIV_SIX - 1);
   localparam logic [3:0]  TICK_LAST_TWELVE  = 4'(TICK_DIV_TWELVE - 1);
   localparam logic [3:0]  TICK_RESET        = 4'h0;
   localparam int          PULSE_OSC_SIX     = 98;
   localparam int          PULSE_OSC_TWELVE  = 196;
   localparam logic [7:0]  PULSE_LAST_SIX    = 8'(PULSE_OSC_SIX - 1);
   localparam logic [7:0]  PULSE_LAST_TWELVE = 8'(PULSE_OSC_TWELVE - 1);
   localparam logic [7:0]  PULSE_RESET       = 8'h00;
   localparam logic [7:0]  READ_ZERO         = 8'h00;
   typedef enum logic [1:0] {OST_IDLE, OST_GOT_FIRST} ost_key_e;
endpackage : ost_pkg

// ---- ost_supervisor.sv ----
// one-time overflow supervisor timer with reset-out pulse
// Functional notes
// - fourteen-bit up-counter, invisible and unwritable by software
// - disabled and idle after any reset until armed
// - arm only by writing 1e then e1 to key register at a6
// - while enabled, count once per machine cycle
// - once enabled stays enabled; only hardware or overflow reset disables
// - key sequence while enabled clears the counter
// - a tick while at 3fff overflows and resets the whole device
// - reset pin high 98 oscillator periods, or 196 in twelve-clock mode
// - key register is write only; reads never return count or keys
`timescale 1ns/1ns
`default_nettype none
module ost_supervisor (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       twelve_clock,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   output var  logic [7:0] sfr_rdata,
   output var  logic       sfr_hit,
   output var  logic       device_reset,
   output var  logic       rst_pin_o,
   output var  logic       rst_pin_oe,
   output var  logic       armed
);
   ost_pkg::ost_key_e key_state;
   ost_pkg::ost_key_e next_key_state;
   logic [13:0]       count;
   logic [13:0]       next_count;
   logic [7:0]        pulse_cnt;
   logic [7:0]        next_pulse_cnt;
   logic [7:0]        pulse_last;
   logic              next_armed;
   logic              pulse_busy;
   logic              next_pulse_busy;
   logic              pulse_start;
   logic              pulse_end;
   logic              tick;
   logic              key_wr;
   logic              key_done;
   logic              overflow;
   logic              core_rst_n;

   // machine-cycle tick; the divider restarts with every reset
   ost_tick u_tick (
      .clk          (clk),
      .rst_n        (core_rst_n),
      .twelve_clock (twelve_clock),
      .tick         (tick)
   );

   // the overflow reset clears the key, arm and count logic and the tick divider just like the hardware reset
   assign core_rst_n = rst_n && !device_reset;
   assign key_wr     = sfr_wr && (sfr_addr == ost_pkg::RESTART_KEY_ADDR);
   assign key_done   = key_wr && (key_state == ost_pkg::OST_GOT_FIRST)
                       && (sfr_wdata == ost_pkg::KEY_SECOND);
   assign overflow   = armed && tick && (count == ost_pkg::COUNT_TERMINAL);
   assign pulse_last = twelve_clock ? ost_pkg::PULSE_LAST_TWELVE : ost_pkg::PULSE_LAST_SIX;
   // start is gated by busy so a second overflow cannot restart a running pulse
   assign pulse_start = !pulse_busy && overflow;
   assign pulse_end   = pulse_busy && (pulse_cnt >= pulse_last);

   // a first key always restarts the sequence, any other value written to the key register drops it
   always_comb begin
      next_key_state = key_state;
      case (key_state)
         ost_pkg::OST_IDLE: begin
            if (key_wr && (sfr_wdata == ost_pkg::KEY_FIRST)) begin
               next_key_state = ost_pkg::OST_GOT_FIRST;
            end
         end
         ost_pkg::OST_GOT_FIRST: begin
            if (key_wr && (sfr_wdata != ost_pkg::KEY_FIRST)) begin
               next_key_state = ost_pkg::OST_IDLE;
            end
         end
         default: begin
            next_key_state = ost_pkg::OST_IDLE;
         end
      endcase
   end

   // sequence state is cleared by the overflow reset as well
   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         key_state <= ost_pkg::OST_IDLE;
      end else begin
         key_state <= next_key_state;
      end
   end

   // no disarm path exists: armed falls only through reset
   always_comb begin
      next_armed = armed;
      if (key_done) begin
         next_armed = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         armed <= 1'b0;
      end else begin
         armed <= next_armed;
      end
   end

   // the counter never reaches the read path, so software cannot see it
   always_comb begin
      next_count = count;
      if (key_done) begin
         next_count = ost_pkg::COUNT_RESET;
      end else if (armed && tick) begin
         next_count = count + 14'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         count <= ost_pkg::COUNT_RESET;
      end else begin
         count <= next_count;
      end
   end

   // pulse logic runs on rst_n only so the overflow reset cannot cut it short
   always_comb begin
      next_pulse_busy = pulse_busy;
      if (pulse_start) begin
         next_pulse_busy = 1'b1;
      end else if (pulse_end) begin
         next_pulse_busy = 1'b0;
      end
   end

   // the counter idles at its last value between pulses
   always_comb begin
      next_pulse_cnt = pulse_cnt;
      if (pulse_start) begin
         next_pulse_cnt = ost_pkg::PULSE_RESET;
      end else if (pulse_busy && !pulse_end) begin
         next_pulse_cnt = pulse_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_busy <= 1'b0;
      end else begin
         pulse_busy <= next_pulse_busy;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_cnt <= ost_pkg::PULSE_RESET;
      end else begin
         pulse_cnt <= next_pulse_cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         device_reset <= 1'b0;
      end else if (pulse_start) begin
         device_reset <= 1'b1;
      end else if (pulse_end) begin
         device_reset <= 1'b0;
      end
   end

   // once released the pin falls back to its pull-down level
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_pin_o <= 1'b0;
      end else if (pulse_start) begin
         rst_pin_o <= 1'b1;
      end else if (pulse_end) begin
         rst_pin_o <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_pin_oe <= 1'b0;
      end else if (pulse_start) begin
         rst_pin_oe <= 1'b1;
      end else if (pulse_end) begin
         rst_pin_oe <= 1'b0;
      end
   end

   // reads of the key address return zero, never the count or keys
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sfr_rdata <= ost_pkg::READ_ZERO;
      end else begin
         sfr_rdata <= ost_pkg::READ_ZERO;
      end
   end

   // hit answers reads and writes alike; the bus never waits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sfr_hit <= 1'b0;
      end else begin
         sfr_hit <= (sfr_rd || sfr_wr) && (sfr_addr == ost_pkg::RESTART_KEY_ADDR);
      end
   end
endmodule : ost_supervisor
`default_nettype wire

// ---- ost_sva.sv ----
// assertion checker for the supervisor timer
`timescale 1ns/1ns
`default_nettype none
module ost_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic twelve_clock,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   input wire logic device_reset,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe,
   input wire logic armed
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] hi_cnt;
   // counts pulse cycles; too long for a repetition
   always_ff @(posedge clk) hi_cnt <= (rst_n && device_reset) ? hi_cnt + 8'h01 : 8'h00;
   a_rd_zero: assert property (sfr_rdata == 8'h00) else $error("rdata");
   a_hit_next: assert property (sfr_rd && sfr_addr == 8'ha6 && !device_reset |=> sfr_hit) else $error("hit");
   a_arm_key: assert property ($rose(armed) |-> $past(sfr_wr && sfr_addr == 8'ha6 && sfr_wdata == 8'he1))
      else $error("arm");
   a_arm_held: assert property ($fell(armed) |-> device_reset) else $error("disarm");
   a_rst_armed: assert property ($rose(device_reset) |-> $past(armed)) else $error("idle reset");
   a_rst_disarm: assert property ($rose(device_reset) |=> !armed) else $error("armed");
   a_pin_level: assert property (rst_pin_o == device_reset && rst_pin_oe == device_reset) else $error("pin");
   a_pulse_len: assert property ($fell(device_reset) |-> hi_cnt == (twelve_clock ? 8'hc4 : 8'h62))
      else $error("pulse");
   c_arm: cover property ($rose(armed));
   c_pulse: cover property ($fell(device_reset));
   c_read: cover property (sfr_rd ##1 sfr_hit);
endmodule : ost_sva
`default_nettype wire

// ---- ost_tb.sv ----
// self-checking bench for the supervisor timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst_n, twelve_clock, sfr_wr, sfr_rd, sfr_hit, device_reset, rst_pin_o, rst_pin_oe, armed;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   int mismatches, check_count, n;
   ost_supervisor i_dut (
      .clk          (clk),
      .rst_n        (rst_n),
      .twelve_clock (twelve_clock),
      .sfr_wr       (sfr_wr),
      .sfr_rd       (sfr_rd),
      .sfr_addr     (sfr_addr),
      .sfr_wdata    (sfr_wdata),
      .sfr_rdata    (sfr_rdata),
      .sfr_hit      (sfr_hit),
      .device_reset (device_reset),
      .rst_pin_o    (rst_pin_o),
      .rst_pin_oe   (rst_pin_oe),
      .armed        (armed)
   );
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task tally_and_finish;
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   // strobe stays up between writes, so back to back writes never glitch it
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
   endtask : wr
   task idle;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask : idle
   task t_read;
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= 8'ha6;
      @(posedge clk);
      sfr_rd <= 1'b0;
      @(negedge clk);
      chk(sfr_hit === 1'b1 && sfr_rdata === 8'h00, "read");
      chk(armed === 1'b0 && rst_pin_oe === 1'b0, "idle");
   endtask : t_read
   task t_keys;
      @(posedge clk);
      wr(8'ha6, 8'h1e);
      wr(8'ha6, 8'h5a);
      wr(8'ha6, 8'he1);
      wr(8'ha5, 8'h1e);
      wr(8'ha5, 8'he1);
      idle();
      chk(armed === 1'b0, "bad keys");
   endtask : t_keys
   task t_hwrst;
      @(posedge clk);
      wr(8'ha6, 8'h1e);
      wr(8'ha6, 8'he1);
      idle();
      chk(armed === 1'b1, "rearm");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(armed === 1'b0 && rst_pin_oe === 1'b0, "hw reset");
   endtask : t_hwrst
   task t_run;
      @(posedge clk);
      wr(8'ha6, 8'h1e);
      wr(8'ha6, 8'he1);
      wr(8'ha6, 8'h00);
      idle();
      chk(armed === 1'b1, "arm");
      repeat (200) @(posedge clk);
      wr(8'ha6, 8'h1e);
      wr(8'ha6, 8'he1);
      idle();
      for (n = 0; n < 99000 && device_reset !== 1'b1; n++) @(negedge clk);
      chk(n > 98290 && n < 98320, "timeout");
      if (n == 99000) tally_and_finish();
      chk(rst_pin_o === 1'b1 && rst_pin_oe === 1'b1, "pin drive");
      for (n = 0; n < 300 && device_reset === 1'b1; n++) @(negedge clk);
      chk(n == 98 && armed === 1'b0, "pulse");
      if (n == 300) tally_and_finish();
   endtask : t_run
   initial begin
      {rst_n, twelve_clock, sfr_wr, sfr_rd} = 4'h0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_read();
      t_keys();
      t_hwrst();
      t_run();
      tally_and_finish();
   end
endmodule : testbench
bind ost_supervisor ost_sva i_sva (.*);
`default_nettype wire

// ---- ost_tick.sv ----
// machine-cycle tick generator
`timescale 1ns/1ns
`default_nettype none
module ost_tick (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic twelve_clock,
   output var  logic tick
);
   logic [3:0] div_cnt;
   logic [3:0] div_last;

   assign div_last = twelve_clock ? ost_pkg::TICK_LAST_TWELVE : ost_pkg::TICK_LAST_SIX;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt <= ost_pkg::TICK_RESET;
         tick    <= 1'b0;
      end else if (div_cnt >= div_last) begin
         div_cnt <= ost_pkg::TICK_RESET;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 4'h1;
         tick    <= 1'b0;
      end
   end
endmodule : ost_tick
`default_nettype wire
